/* File: rtl/otr_cfg.svh */
/*
 * Offsets, field positions, reset values and command codes of the
 * over-temperature fault response block.
 * Assumes it is included by bare name from the modules that use its macros.
 */
`ifndef OTR_CFG_SVH
`define OTR_CFG_SVH

// Command codes of the PMBus command layer.
`define OTR_OC_WARN_OFS     8'h4a
`define OTR_OT_LIMIT_OFS    8'h4f
`define OTR_OT_ACTION_OFS   8'h50
`define OTR_STATUS_OFS      8'h7d
`define OTR_CLEAR_FAULTS    8'h03

// Reset values.
`define OTR_OC_WARN_RST     16'h7bff
`define OTR_OT_LIMIT_RST    16'h7bff
`define OTR_OT_ACTION_RST   8'hc0

// Field positions of the action register.
`define OTR_RESP_HI         7
`define OTR_RESP_LO         6
`define OTR_RETRY_HI        5
`define OTR_RETRY_LO        3
`define OTR_DELAY_HI        2
`define OTR_DELAY_LO        0

// Retry code for endless retries and status bit of the fault.
`define OTR_RETRY_ENDLESS   3'h7
`define OTR_STATUS_OT_BIT   7

`endif

/* File: rtl/otr_pkg.sv */
/*
 * Types and conversion functions of the over-temperature fault response.
 * Assumes the constants header otr_cfg.svh is on the include path.
 */
package otr_pkg;

    typedef enum logic [1:0] {
        RESP_IGNORE    = 2'b00,
        RESP_RUN_DELAY = 2'b01,
        RESP_OFF_RETRY = 2'b10,
        RESP_OFF_LATCH = 2'b11
    } otr_resp_e;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_RUN   = 3'b001,
        ST_RIDE  = 3'b010,
        ST_WAIT  = 3'b011,
        ST_LATCH = 3'b100
    } otr_state_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } otr_cmd_s;

    typedef struct packed {
        logic        valid;
        logic        ack;
        logic [15:0] data;
    } otr_rsp_s;

    // Linear format to fixed point with sixteen fraction bits.
    function automatic logic signed [47:0] otr_lin_to_fix(input logic [15:0] v);
        logic signed [47:0] m;
        logic [4:0]         sh;
        m  = 48'(signed'(v[10:0]));
        sh = {~v[15], v[14:11]};
        return m <<< sh;
    endfunction

    // True when the measured value reaches or passes the limit.
    function automatic logic otr_at_or_over(input logic [15:0] meas,
                                            input logic [15:0] limit);
        return otr_lin_to_fix(meas) >= otr_lin_to_fix(limit);
    endfunction

endpackage

/* File: rtl/otr_sync2.sv */
/*
 * Two-stage synchroniser for pin inputs.
 * Assumes the inputs are levels from outside the clock domain.
 */
`timescale 1ns/1ps
module otr_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // otr_sync2

/* File: rtl/otr_delay_timer.sv */
/*
 * Delay timer counting a power of two of delay units.
 * Assumes unit_tick is a one-cycle pulse from the delay time base.
 */
`timescale 1ns/1ps
module otr_delay_timer (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Control
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic       unit_tick,
    input  wire logic [2:0] code,
    // Expiry
    output logic            done
);
    logic       active;
    logic [7:0] units;
    wire  [8:0] target = 9'h001 << code;
    wire  [7:0] last   = 8'(target - 9'h001);

    always_ff @(posedge clock) begin
        if (!rst_n || stop) begin
            active <= 1'b0;
            units  <= 8'h00;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                active <= 1'b1;
                units  <= 8'h00;
            end else if (active && unit_tick) begin
                if (units == last) begin
                    active <= 1'b0;
                    done   <= 1'b1;
                end else begin
                    units <= units + 8'h01;
                end
            end
        end
    end
endmodule // otr_delay_timer

/* File: rtl/otr_fault_response.sv */
/*
 * Over-temperature fault response of the management side: threshold
 * registers, command decode, fault state machine and retry handling.
 * Assumes measurements, delay tick and the operation bit come from logic
 * on the same clock; the control pin and reset pin come from outside.
 */
// Overview of operation
// - Response 00 keeps output running through fault.
// - Response 01 keeps running for programmed delay.
// - After that delay, persisting fault follows retry setting.
// - Response 10 disables output, then follows retries.
// - Response 11 holds output off until cleared.
// - Status bit clear or clear-faults command clears.
// - Asserted reset pin clears the latched fault.
// - Commanding output off then on clears fault.
// - Retry 000 means no restart, stay off.
// - Retry 001 means exactly one restart.
// - Retry 010 means exactly two restarts.
// - Retry 011 means exactly three restarts.
// - Retry 100 means exactly four restarts.
// - All restarts failed: output off until cleared.
// - Restart starts spaced by programmed delay count.
// - Programmable 16-bit linear over-temperature fault limit.
// - Programmable 16-bit linear over-current warning limit.
// - Delay code selects one to 128 units.
// - Retry 111 retries endlessly until commanded off.
// - Every response sets the fault status bit.
`timescale 1ns/1ps
`include "otr_cfg.svh"
module otr_fault_response
    import otr_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // PMBus command layer
    input  wire otr_cmd_s    cmd,
    output otr_rsp_s         rsp,
    // Measurements and delay time base
    input  wire logic [15:0] temp_meas,
    input  wire logic [15:0] iout_meas,
    input  wire logic        unit_tick,
    // Output commanding
    input  wire logic        ctrl_pin,
    input  wire logic        op_on,
    input  wire logic        fault_reset_pin,
    // Results
    output logic             out_enable,
    output logic             ot_fault_status,
    output logic             oc_warning
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and synchronised pins.

    logic [15:0] overcurrent_warning_threshold;
    logic [15:0] overtemp_fault_threshold;
    logic [7:0]  overtemp_fault_action;
    otr_state_e  state;
    otr_state_e  next_state;
    logic [2:0]  attempts;
    logic [2:0]  next_attempts;
    logic        on_q;
    logic        tmr_start;
    logic        tmr_done;
    logic        ctrl_sync;
    logic        reset_sync;

    otr_sync2 #(
        .W (2)
    ) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({ctrl_pin, fault_reset_pin}),
        .q     ({ctrl_sync, reset_sync})
    );

    ////////////////////////////////////////////////////////////////////////
    // Command decode.

    wire cmd_wr       = cmd.valid && cmd.write;
    wire cmd_rd       = cmd.valid && !cmd.write;
    wire hit_oc       = cmd.code == `OTR_OC_WARN_OFS;
    wire hit_ot       = cmd.code == `OTR_OT_LIMIT_OFS;
    wire hit_action   = cmd.code == `OTR_OT_ACTION_OFS;
    wire hit_status   = cmd.code == `OTR_STATUS_OFS;
    wire hit_clear    = cmd.code == `OTR_CLEAR_FAULTS;
    wire clear_cmd    = cmd_wr && hit_clear;
    wire status_clr   = cmd_wr && hit_status && cmd.wdata[`OTR_STATUS_OT_BIT];
    wire read_hit     = hit_oc || hit_ot || hit_action || hit_status;

    wire [7:0] status_byte = {ot_fault_status, 7'h00};
    wire [15:0] read_data  = hit_oc     ? overcurrent_warning_threshold :
                             hit_ot     ? overtemp_fault_threshold :
                             hit_action ? {8'h00, overtemp_fault_action} :
                             hit_status ? {8'h00, status_byte} : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Field decode and fault detection.

    otr_resp_e resp;
    assign resp = otr_resp_e'(overtemp_fault_action[`OTR_RESP_HI:`OTR_RESP_LO]);

    wire [2:0] retry_set  = overtemp_fault_action[`OTR_RETRY_HI:`OTR_RETRY_LO];
    wire [2:0] delay_code = overtemp_fault_action[`OTR_DELAY_HI:`OTR_DELAY_LO];
    wire       endless    = retry_set == `OTR_RETRY_ENDLESS;
    wire       ot_over    = otr_at_or_over(temp_meas, overtemp_fault_threshold);
    wire       oc_over    = otr_at_or_over(iout_meas, overcurrent_warning_threshold);
    wire       on_now     = ctrl_sync && op_on;
    wire       on_rise    = on_now && !on_q;
    wire       clear_any  = clear_cmd || status_clr || reset_sync || on_rise;
    wire       last_try   = (attempts + 3'h1) >= retry_set;
    wire       out_next   = next_state == ST_RUN || next_state == ST_RIDE;

    ////////////////////////////////////////////////////////////////////////
    // Fault state machine.

    always_comb begin
        next_state    = state;
        next_attempts = attempts;
        tmr_start     = 1'b0;
        case (state)
            ST_OFF: begin
                next_attempts = 3'h0;
                if (on_now) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_attempts = 3'h0;
                if (ot_over) begin
                    case (resp)
                        RESP_IGNORE: begin
                            next_state = ST_RUN;
                        end
                        RESP_RUN_DELAY: begin
                            next_state = ST_RIDE;
                            tmr_start  = 1'b1;
                        end
                        RESP_OFF_RETRY: begin
                            if (retry_set == 3'h0) begin
                                next_state = ST_LATCH;
                            end else begin
                                next_state = ST_WAIT;
                                tmr_start  = 1'b1;
                            end
                        end
                        default: begin
                            next_state = ST_LATCH;
                        end
                    endcase
                end
            end
            ST_RIDE: begin
                if (tmr_done) begin
                    if (!ot_over) begin
                        next_state = ST_RUN;
                    end else if (retry_set == 3'h0) begin
                        next_state = ST_LATCH;
                    end else begin
                        next_state = ST_WAIT;
                        tmr_start  = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    if (!ot_over) begin
                        next_state = ST_RUN;
                    end else if (endless) begin
                        tmr_start = 1'b1;
                    end else if (last_try) begin
                        next_state = ST_LATCH;
                    end else begin
                        next_attempts = attempts + 3'h1;
                        tmr_start     = 1'b1;
                    end
                end
            end
            ST_LATCH: begin
                if (clear_cmd || status_clr || reset_sync) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (!on_now) begin
            next_state = ST_OFF;
            tmr_start  = 1'b0;
        end
    end

    otr_delay_timer u_timer (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (tmr_start),
        .stop      (!(next_state == ST_RIDE || next_state == ST_WAIT)),
        .unit_tick (unit_tick),
        .code      (delay_code),
        .done      (tmr_done)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state      <= ST_OFF;
            attempts   <= 3'h0;
            on_q       <= 1'b0;
            out_enable <= 1'b0;
        end else begin
            state      <= next_state;
            attempts   <= next_attempts;
            on_q       <= on_now;
            out_enable <= out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold registers and status.

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overcurrent_warning_threshold <= `OTR_OC_WARN_RST;
            overtemp_fault_threshold      <= `OTR_OT_LIMIT_RST;
            overtemp_fault_action         <= `OTR_OT_ACTION_RST;
        end else if (cmd_wr) begin
            if (hit_oc) begin
                overcurrent_warning_threshold <= cmd.wdata;
            end
            if (hit_ot) begin
                overtemp_fault_threshold <= cmd.wdata;
            end
            if (hit_action) begin
                overtemp_fault_action <= cmd.wdata[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ot_fault_status <= 1'b0;
            oc_warning      <= 1'b0;
            rsp             <= '0;
        end else begin
            if (ot_over) begin
                ot_fault_status <= 1'b1;
            end else if (clear_any) begin
                ot_fault_status <= 1'b0;
            end
            oc_warning <= oc_over;
            rsp.valid  <= cmd_rd;
            rsp.ack    <= cmd_rd && read_hit;
            rsp.data   <= cmd_rd ? read_data : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_run_fault;
        state == ST_RUN && ot_over && on_now;
    endsequence

    sequence s_wait_fail;
        state == ST_WAIT && tmr_done && ot_over && on_now;
    endsequence

    sequence s_wait_pass;
        state == ST_WAIT && tmr_done && !ot_over && on_now;
    endsequence

    property p_ignore;
        s_run_fault and (resp == RESP_IGNORE) |=> out_enable && state == ST_RUN;
    endproperty
    a_ignore: assert property (p_ignore) else $error("Ignored fault stopped output.");

    property p_ride;
        s_run_fault and (resp == RESP_RUN_DELAY) |=> out_enable && state == ST_RIDE;
    endproperty
    a_ride: assert property (p_ride) else $error("Delay mode did not keep running.");

    property p_ride_end;
        state == ST_RIDE && tmr_done && ot_over && on_now && retry_set == 3'h0
            |=> state == ST_LATCH && !out_enable;
    endproperty
    a_ride_end: assert property (p_ride_end) else $error("Delay end ignored retries.");

    property p_off_retry;
        s_run_fault and (resp == RESP_OFF_RETRY) |=> !out_enable;
    endproperty
    a_off_retry: assert property (p_off_retry) else $error("Output not disabled.");

    property p_latch_hold;
        state == ST_LATCH && on_now && !clear_cmd && !status_clr && !reset_sync
            |=> state == ST_LATCH && !out_enable;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latch left early.");

    property p_clear;
        state == ST_LATCH && on_now && (clear_cmd || status_clr) |=> state == ST_RUN;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not release latch.");

    property p_reset_pin;
        state == ST_LATCH && on_now && reset_sync |=> out_enable;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("Reset pin ignored.");

    property p_cycle;
        !on_now ##1 on_now |=> out_enable && state == ST_RUN;
    endproperty
    a_cycle: assert property (p_cycle) else $error("Off then on did not restart.");

    property p_exhaust;
        s_wait_fail and (!endless && last_try) |=> state == ST_LATCH && !out_enable;
    endproperty
    a_exhaust: assert property (p_exhaust) else $error("Retries not exhausted.");

    property p_no_retry;
        s_run_fault and (resp == RESP_OFF_RETRY && retry_set == 3'h0)
            |=> state == ST_LATCH && !out_enable;
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("Retry 000 restarted.");

    property p_restart;
        s_wait_pass |=> state == ST_RUN && out_enable;
    endproperty
    a_restart: assert property (p_restart) else $error("Cool retry did not restart.");

    property p_limit_write;
        cmd_wr && hit_ot |=> overtemp_fault_threshold == $past(cmd.wdata);
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("Limit not written.");

    property p_endless;
        s_wait_fail and endless |=> state == ST_WAIT && attempts == $past(attempts);
    endproperty
    a_endless: assert property (p_endless) else $error("Endless retry stopped.");

    property p_status;
        ot_over |=> ot_fault_status;
    endproperty
    a_status: assert property (p_status) else $error("Fault status not set.");

endmodule // otr_fault_response

/* File: tb/otr_host_model.sv */
/* PMBus host model that issues commands to the fault response block.
   Assumes commands are taken on the rising clock edge. */
`timescale 1ns/1ps
`include "otr_cfg.svh"
module otr_host_model
    import otr_pkg::*;
(
    // Clock
    input  wire logic     clock,
    // Command layer
    output otr_cmd_s      cmd,
    input  wire otr_rsp_s rsp
);
    initial begin
        cmd = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Holds a command for one taking edge, then scrambles the idle fields.
    task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge clock);
        #1;
        cmd = '{1'b1, w, c, d};
        @(posedge clock);
        #1;
        cmd = '{1'b0, ~w, ~c, ~d};
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        issue(1'b1, c, d);
    endtask
    // Reads a register and waits a bounded time for the answer.
    task automatic rd(input logic [7:0] c, output logic ack, output logic [15:0] d);
        int n;
        issue(1'b0, c, 16'h0000);
        n = 0;
        while (rsp.valid !== 1'b1 && n < 3) begin
            @(posedge clock);
            #1;
            n++;
        end
        ack = (rsp.valid === 1'b1) ? rsp.ack : 1'bx;
        d   = (rsp.valid === 1'b1) ? rsp.data : 16'hxxxx;
    endtask
    task automatic clear_all();
        issue(1'b1, `OTR_CLEAR_FAULTS, 16'h0000);
    endtask
    task automatic clear_status();
        issue(1'b1, `OTR_STATUS_OFS, 16'h0080);
    endtask
endmodule // otr_host_model

/* File: tb/otr_fault_response_tb_top.sv */
/* Self-checking testbench of the over-temperature fault response.
   Assumes the package, the design files and the host model are compiled. */
`timescale 1ns/1ps
`include "otr_cfg.svh"
module otr_fault_response_tb_top
    import otr_pkg::*;
;
    localparam logic [15:0] LIMIT = 16'h0064;
    localparam logic [15:0] COOL  = 16'h0063;
    logic        clock;
    logic        rst_n;
    otr_cmd_s    cmd;
    otr_rsp_s    rsp;
    logic [15:0] temp_meas;
    logic [15:0] iout_meas;
    logic        unit_tick;
    logic        ctrl_pin;
    logic        op_on;
    logic        fault_reset_pin;
    logic        out_enable;
    logic        ot_fault_status;
    logic        oc_warning;
    logic        ack;
    logic [15:0] rdata;
    logic [15:0] rv;
    int          error_cnt;
    int          cmp_count;
    int          n;
    int          mdl_reg[int];
    int          codes[$];

    otr_fault_response dut (
        .clock           (clock),
        .rst_n           (rst_n),
        .cmd             (cmd),
        .rsp             (rsp),
        .temp_meas       (temp_meas),
        .iout_meas       (iout_meas),
        .unit_tick       (unit_tick),
        .ctrl_pin        (ctrl_pin),
        .op_on           (op_on),
        .fault_reset_pin (fault_reset_pin),
        .out_enable      (out_enable),
        .ot_fault_status (ot_fault_status),
        .oc_warning      (oc_warning)
    );
    otr_host_model host (
        .clock (clock),
        .cmd   (cmd),
        .rsp   (rsp)
    );

    initial begin
        clock = 1'b0;
    end
    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] c);
        logic [15:0] want;
        want = mdl_reg.exists(c) ? 16'(mdl_reg[c]) : 16'h0000;
        host.rd(c, ack, rdata);
        chk("ack", {15'h0000, ack}, {15'h0000, mdl_reg.exists(c) != 0});
        chk("rdata", rdata, want);
    endtask
    // Each pulse is one delay unit; the wait after it lets the response act.
    task automatic pulse(input int k);
        repeat (k) begin
            unit_tick = 1'b1;
            step(1);
            unit_tick = 1'b0;
            step(4);
        end
    endtask
    task automatic set_act(input logic [1:0] r, input logic [2:0] t, input logic [2:0] c);
        host.wr(`OTR_OT_ACTION_OFS, {8'h00, r, t, c});
        mdl_reg['h50] = {r, t, c};
    endtask
    task automatic hot();
        temp_meas = LIMIT;
        step(3);
    endtask
    task automatic recover();
        temp_meas = COOL;
        host.clear_all();
        step(3);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clock);
        error_cnt++;
        $display("FAIL watchdog expected done seen hang");
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        temp_meas = COOL;
        iout_meas = 16'h0000;
        unit_tick = 1'b0;
        ctrl_pin = 1'b1;
        op_on = 1'b1;
        fault_reset_pin = 1'b0;
        mdl_reg['h4a] = `OTR_OC_WARN_RST;
        mdl_reg['h4f] = `OTR_OT_LIMIT_RST;
        mdl_reg['h50] = `OTR_OT_ACTION_RST;
        mdl_reg['h7d] = 0;
        void'($urandom(61830));
        step(5);
        rst_n = 1'b1;
        step(4);
        codes = '{'h4a, 'h4f, 'h50, 'h7d, 'h51};
        foreach (codes[i]) begin
            rdchk(codes[i][7:0]);
        end
        rv = 16'($urandom);
        host.wr(`OTR_OC_WARN_OFS, rv);
        mdl_reg['h4a] = rv;
        rdchk(8'h4a);
        host.wr(`OTR_OT_LIMIT_OFS, LIMIT);
        mdl_reg['h4f] = LIMIT;
        rdchk(8'h4f);
        host.wr(`OTR_OT_ACTION_OFS, 16'h1234);
        mdl_reg['h50] = 'h34;
        rdchk(8'h50);
        host.wr(`OTR_OC_WARN_OFS, LIMIT);
        iout_meas = LIMIT;
        step(3);
        chk("oc_warning", oc_warning, 1'b1);
        iout_meas = COOL;
        step(3);
        chk("oc_warning", oc_warning, 1'b0);
        $display("test registers done");
        set_act(2'b00, 3'b000, 3'b000);
        chk("status", ot_fault_status, 1'b0);
        hot();
        chk("status", ot_fault_status, 1'b1);
        pulse(3);
        chk("out_enable", out_enable, 1'b1);
        recover();
        $display("test ignore done");
        codes = '{0, 1, 2, 3, 4, 5, 6, 7};
        foreach (codes[i]) begin
            for (int b = 0; b < 2; b++) begin
                n = (codes[i] == 7) ? 9 : codes[i];
                if (b == 0 || (n > 0 && n < 9)) begin
                    set_act(2'b10, codes[i][2:0], 3'b000);
                    hot();
                    chk("out_enable", out_enable, 1'b0);
                    pulse((b == 1) ? n : ((n > 0) ? n - 1 : 0));
                    temp_meas = COOL;
                    pulse(2);
                    chk("out_enable", out_enable, b == 0 && n > 0);
                    recover();
                end
            end
        end
        $display("test retry count done");
        for (int c = 0; c < 8; c++) begin
            set_act(2'b10, 3'($urandom_range(4, 1)), 3'(c));
            hot();
            temp_meas = COOL;
            pulse((1 << c) - 1);
            chk("out_enable", out_enable, 1'b0);
            pulse(1);
            chk("out_enable", out_enable, 1'b1);
            recover();
        end
        $display("test retry spacing done");
        set_act(2'b01, 3'b000, 3'b001);
        hot();
        pulse(1);
        chk("out_enable", out_enable, 1'b1);
        pulse(1);
        chk("out_enable", out_enable, 1'b0);
        recover();
        hot();
        temp_meas = COOL;
        pulse(2);
        chk("out_enable", out_enable, 1'b1);
        recover();
        set_act(2'b01, 3'b001, 3'b000);
        hot();
        pulse(1);
        chk("out_enable", out_enable, 1'b0);
        temp_meas = COOL;
        pulse(1);
        chk("out_enable", out_enable, 1'b1);
        recover();
        $display("test run with delay done");
        for (int m = 0; m < 5; m++) begin
            set_act(2'b11, 3'b001, 3'b000);
            hot();
            temp_meas = COOL;
            pulse(2);
            chk("out_enable", out_enable, 1'b0);
            case (m)
                0: host.clear_all();
                1: host.clear_status();
                2: begin
                    fault_reset_pin = 1'b1;
                    step(4);
                    fault_reset_pin = 1'b0;
                end
                3: begin
                    op_on = 1'b0;
                    step(3);
                    op_on = 1'b1;
                end
                default: begin
                    ctrl_pin = 1'b0;
                    step(4);
                    ctrl_pin = 1'b1;
                end
            endcase
            step(6);
            chk("out_enable", out_enable, 1'b1);
            chk("status", ot_fault_status, 1'b0);
        end
        $display("test latch and clear done");
        summarize();
    end
endmodule // otr_fault_response_tb_top
